/* File: liuts_regs.sv */
// Control and status register bank of the line interface unit
`timescale 1ns/1ps
// How it works
// - Equalizer enable bit turns on the serial input trace equalizer.
// - Two-bit boost field picks coax driver amplitude; code 10 reserved.
// - Loopback bit routes decoded receive data into transmit clock recovery.
// - Line mode zero: coax coding and driver off, optical outputs used.
// - Line mode one (reset): coax coding on, optical off, coax driven.
// - Status bit four reports a receive loss-of-signal condition.
// - Status bit three reports receive clock off reference beyond 100ppm.
// - Status bit one reports no valid serial transmit input.
// - Status bit zero sets when transmit FIFO error asserts.
// - FIFO error flag clears while FIFO reset control is asserted.
// - FIFO reset control recentres transmit FIFO pointers.
module liuts_regs (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic rx_los_in,
  input wire logic rx_lol_in,
  input wire logic tx_lol_in,
  input wire logic fifo_err_in,
  output liuts_pkg::liuts_ctrl_s ctrl_out,
  output logic [1:0] coax_tx_out,
  output logic [1:0] optical_tx_out,
  input wire logic serial_tx_data_in,
  input wire logic line_rx_in,
  output logic loop_data_out,
  output logic irq_out
);
  logic [7:0] adv_one_q;
  logic [7:0] adv_one_d;
  logic [7:0] adv_zero_q;
  logic [7:0] adv_zero_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic fifo_rst_q;
  logic fifo_rst_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  liuts_pkg::liuts_ctrl_s ctrl_q;
  liuts_pkg::liuts_ctrl_s ctrl_d;
  logic [1:0] coax_q;
  logic [1:0] coax_d;
  logic [1:0] optical_q;
  logic [1:0] optical_d;
  logic loop_q;
  logic loop_d;
  logic irq_q;
  logic irq_d;
  logic [3:0] cond;
  logic [3:0] flags;
  logic [7:0] status;
  logic stat_rd;
  logic [1:0] boost_wr;

  assign cond = {rx_los_in, rx_lol_in, tx_lol_in, fifo_err_in};
  assign stat_rd = rd_in && (addr_in == liuts_pkg::ADDR_STATUS_MONITOR);

  // One latch per monitored condition
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_flag
      liuts_flag u_flag (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .cond_in(cond[gi]),
        .rd_clr_in(stat_rd),
        .force_clr_in((gi == 0) && fifo_rst_q),
        .flag_out(flags[gi])
      );
    end
  endgenerate

  always_comb
  begin
    status = liuts_pkg::ZERO_BYTE;
    status[liuts_pkg::RX_LOS_BIT] = flags[3];
    status[liuts_pkg::RX_LOL_BIT] = flags[2];
    status[liuts_pkg::TX_LOL_BIT] = flags[1];
    status[liuts_pkg::FIFO_ERR_BIT] = flags[0];
  end

  // Register writes
  always_comb
  begin
    adv_one_d = adv_one_q;
    adv_zero_d = adv_zero_q;
    mode_d = mode_q;
    fifo_rst_d = fifo_rst_q;
    mask_d = mask_q;
    boost_wr = wdata_in[liuts_pkg::BOOST_LSB +: 2];
    if (wr_in)
    begin
      unique case (addr_in)
        liuts_pkg::ADDR_ADV_TX_CTRL_ONE: adv_one_d = wdata_in;
        liuts_pkg::ADDR_ADV_TX_CTRL_ZERO:
        begin
          adv_zero_d = wdata_in;
          // Reserved code keeps the previous amplitude
          if (boost_wr == liuts_pkg::BOOST_RSVD)
            adv_zero_d[liuts_pkg::BOOST_LSB +: 2] =
              adv_zero_q[liuts_pkg::BOOST_LSB +: 2];
        end
        liuts_pkg::ADDR_LINE_MODE_CTRL: mode_d = wdata_in;
        liuts_pkg::ADDR_FIFO_CTRL:
          fifo_rst_d = wdata_in[liuts_pkg::FIFO_RST_BIT];
        liuts_pkg::ADDR_IRQ_MASK: mask_d = wdata_in & liuts_pkg::STATUS_USED;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always_comb
  begin
    rdata_d = liuts_pkg::ZERO_BYTE;
    if (rd_in)
    begin
      unique case (addr_in)
        liuts_pkg::ADDR_ADV_TX_CTRL_ONE: rdata_d = adv_one_q;
        liuts_pkg::ADDR_ADV_TX_CTRL_ZERO: rdata_d = adv_zero_q;
        liuts_pkg::ADDR_LINE_MODE_CTRL: rdata_d = mode_q;
        liuts_pkg::ADDR_STATUS_MONITOR: rdata_d = status;
        liuts_pkg::ADDR_FIFO_CTRL:
          rdata_d = {7'h00, fifo_rst_q};
        liuts_pkg::ADDR_IRQ_MASK: rdata_d = mask_q;
        default: rdata_d = liuts_pkg::ZERO_BYTE;
      endcase
    end
  end

  // Datapath steering from the control bits
  always_comb
  begin
    ctrl_d.equalizer_en = adv_one_q[liuts_pkg::EQ_EN_BIT];
    ctrl_d.boost_level = adv_zero_q[liuts_pkg::BOOST_LSB +: 2];
    ctrl_d.loopback_en = adv_zero_q[liuts_pkg::LOOPBACK_BIT];
    ctrl_d.coax_mode = mode_q[liuts_pkg::LINE_MODE_BIT];
    ctrl_d.optical_mode = !mode_q[liuts_pkg::LINE_MODE_BIT];
    ctrl_d.fifo_ptr_reset = fifo_rst_q;
    loop_d = adv_zero_q[liuts_pkg::LOOPBACK_BIT] ? line_rx_in : 1'b0;
    coax_d = 2'h0;
    optical_d = 2'h0;
    if (mode_q[liuts_pkg::LINE_MODE_BIT])
      coax_d = {serial_tx_data_in, !serial_tx_data_in};
    else
      optical_d = {serial_tx_data_in, !serial_tx_data_in};
    irq_d = |(status & mask_q);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      adv_one_q <= liuts_pkg::ADV_ONE_RESET;
      adv_zero_q <= liuts_pkg::ADV_ZERO_RESET;
      mode_q <= liuts_pkg::LINE_MODE_RESET;
      fifo_rst_q <= 1'b0;
      mask_q <= liuts_pkg::MASK_RESET;
      rdata_q <= liuts_pkg::ZERO_BYTE;
      ctrl_q <= '{
        equalizer_en: 1'b0,
        boost_level: liuts_pkg::BOOST_NORMAL,
        loopback_en: 1'b0,
        coax_mode: liuts_pkg::LINE_MODE_RESET[liuts_pkg::LINE_MODE_BIT],
        optical_mode: !liuts_pkg::LINE_MODE_RESET[liuts_pkg::LINE_MODE_BIT],
        fifo_ptr_reset: 1'b0
      };
      coax_q <= 2'h0;
      optical_q <= 2'h0;
      loop_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      adv_one_q <= adv_one_d;
      adv_zero_q <= adv_zero_d;
      mode_q <= mode_d;
      fifo_rst_q <= fifo_rst_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      coax_q <= coax_d;
      optical_q <= optical_d;
      loop_q <= loop_d;
      irq_q <= irq_d;
    end
  end

  assign rdata_out = rdata_q;
  assign ctrl_out = ctrl_q;
  assign coax_tx_out = coax_q;
  assign optical_tx_out = optical_q;
  assign loop_data_out = loop_q;
  assign irq_out = irq_q;

  eq_follow_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_in && addr_in == liuts_pkg::ADDR_ADV_TX_CTRL_ONE
    |=> ##1 ctrl_out.equalizer_en == $past(wdata_in[0], 2))
    else $error("equalizer enable did not follow write");
  boost_rsvd_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ctrl_out.boost_level != liuts_pkg::BOOST_RSVD)
    else $error("reserved boost code reached driver");
  loop_route_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ctrl_q.loopback_en && $past(adv_zero_q[0]) |-> loop_data_out == $past(line_rx_in))
    else $error("loopback data not routed");
  optical_sel_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && !$past(mode_q[7])
    |-> coax_tx_out == 2'h0 && ctrl_out.optical_mode)
    else $error("coax active in optical mode");
  coax_sel_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(mode_q[7]) |-> optical_tx_out == 2'h0)
    else $error("optical active in coax mode");
  los_latch_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rx_los_in |=> status[4])
    else $error("signal loss not latched");
  lol_latch_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rx_lol_in |=> status[3])
    else $error("receive lock loss not latched");
  tx_lock_lost_flag_latch_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    tx_lol_in |=> status[1])
    else $error("transmit lock loss not latched");
  tx_fifo_error_flag_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fifo_err_in && !fifo_rst_q |=> status[0])
    else $error("fifo error not latched");
  tx_fifo_error_flag_clr_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fifo_rst_q |=> !status[0])
    else $error("fifo error survived reset control");
  rd_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    stat_rd && cond == 4'h0 |=> status == liuts_pkg::ZERO_BYTE)
    else $error("read did not clear idle flags");
  test_zero_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rd_in && (addr_in == liuts_pkg::ADDR_TEST_RSVD_A ||
    addr_in == liuts_pkg::ADDR_TEST_RSVD_B) |=> rdata_out == 8'h00)
    else $error("test register read nonzero");
  irq_level_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ##1 irq_out == |($past(status) & $past(mask_q)))
    else $error("interrupt does not match masked status");

  // Bus and datapath checks
  rdata_idle_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !rd_in |=> rdata_out == liuts_pkg::ZERO_BYTE)
    else $error("read data present without a read");
  boost_keep_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_in && addr_in == liuts_pkg::ADDR_ADV_TX_CTRL_ZERO &&
    wdata_in[liuts_pkg::BOOST_LSB +: 2] == liuts_pkg::BOOST_RSVD
    |=> $stable(adv_zero_q[liuts_pkg::BOOST_LSB +: 2]))
    else $error("reserved boost code changed amplitude");
  loop_off_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !adv_zero_q[liuts_pkg::LOOPBACK_BIT] |=> !loop_data_out)
    else $error("loopback data leaked while disabled");
  coax_data_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(mode_q[liuts_pkg::LINE_MODE_BIT])
    |-> coax_tx_out == {$past(serial_tx_data_in), !$past(serial_tx_data_in)})
    else $error("coax outputs do not carry transmit data");
  optical_data_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) && !$past(mode_q[liuts_pkg::LINE_MODE_BIT])
    |-> optical_tx_out == {$past(serial_tx_data_in), !$past(serial_tx_data_in)})
    else $error("optical outputs do not carry transmit data");
  ptr_reset_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    ##1 ctrl_out.fifo_ptr_reset == $past(fifo_rst_q))
    else $error("pointer reset control not forwarded");
  mode_excl_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    ctrl_out.coax_mode != ctrl_out.optical_mode)
    else $error("both or neither line interface selected");
  mask_used_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (mask_q & ~liuts_pkg::STATUS_USED) == liuts_pkg::ZERO_BYTE)
    else $error("mask holds an unused bit");
  test_write_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_in && (addr_in == liuts_pkg::ADDR_TEST_RSVD_A ||
    addr_in == liuts_pkg::ADDR_TEST_RSVD_B)
    |=> $stable(adv_one_q) && $stable(adv_zero_q) && $stable(mode_q))
    else $error("test register write changed control state");
  read_mode_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    rd_in && addr_in == liuts_pkg::ADDR_LINE_MODE_CTRL
    |=> rdata_out == $past(mode_q))
    else $error("mode register read back wrong");
  read_eq_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    rd_in && addr_in == liuts_pkg::ADDR_ADV_TX_CTRL_ONE
    |=> rdata_out == $past(adv_one_q))
    else $error("equalizer register read back wrong");
  read_fifo_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    rd_in && addr_in == liuts_pkg::ADDR_FIFO_CTRL
    |=> rdata_out == {7'h00, $past(fifo_rst_q)})
    else $error("fifo control read back wrong");
endmodule

/* File: liuts_pkg.sv */
// Register map, field positions and reset values of the control and status bank
package liuts_pkg;
  // Register offsets (page 1 addresses, byte index 2..9)
  localparam logic [3:0] ADDR_ADV_TX_CTRL_ONE = 4'h2;
  localparam logic [3:0] ADDR_ADV_TX_CTRL_ZERO = 4'h3;
  localparam logic [3:0] ADDR_LINE_MODE_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STATUS_MONITOR = 4'h5;
  localparam logic [3:0] ADDR_TEST_RSVD_A = 4'h6;
  localparam logic [3:0] ADDR_TEST_RSVD_B = 4'h7;
  localparam logic [3:0] ADDR_FIFO_CTRL = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
  // Field positions
  localparam int EQ_EN_BIT = 0;
  localparam int LOOPBACK_BIT = 0;
  localparam int BOOST_LSB = 1;
  localparam int LINE_MODE_BIT = 7;
  localparam int FIFO_RST_BIT = 0;
  localparam int RX_LOS_BIT = 4;
  localparam int RX_LOL_BIT = 3;
  localparam int TX_LOL_BIT = 1;
  localparam int FIFO_ERR_BIT = 0;
  // Reset values
  localparam logic [7:0] ADV_ONE_RESET = 8'h00;
  localparam logic [7:0] ADV_ZERO_RESET = 8'hA8;
  localparam logic [7:0] LINE_MODE_RESET = 8'h80;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] STATUS_USED = 8'h1B;
  // Boost codes
  localparam logic [1:0] BOOST_NORMAL = 2'h0;
  localparam logic [1:0] BOOST_FIVE = 2'h1;
  localparam logic [1:0] BOOST_RSVD = 2'h2;
  localparam logic [1:0] BOOST_TEN = 2'h3;

  typedef struct packed {
    logic rx_los;
    logic rx_lol;
    logic tx_lol;
    logic fifo_err;
  } liuts_cond_s;

  typedef struct packed {
    logic equalizer_en;
    logic [1:0] boost_level;
    logic loopback_en;
    logic coax_mode;
    logic optical_mode;
    logic fifo_ptr_reset;
  } liuts_ctrl_s;
endpackage

/* File: liuts_flag.sv */
// One latched status flag: sets on condition, clears on read, held by clear
`timescale 1ns/1ps
module liuts_flag (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cond_in,
  input wire logic rd_clr_in,
  input wire logic force_clr_in,
  output logic flag_out
);
  logic flag_q;
  logic flag_d;

  always_comb
  begin
    flag_d = flag_q;
    if (force_clr_in)
      flag_d = 1'b0;
    else if (cond_in)
      flag_d = 1'b1;
    else if (rd_clr_in)
      flag_d = 1'b0;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  assign flag_out = flag_q;

  set_wins_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    cond_in && !force_clr_in |=> flag_q)
    else $error("flag lost an event");
endmodule

/* File: liuts_regs_tb.sv */
// Self-checking testbench of the control and status register bank
`timescale 1ns/1ps
module liuts_regs_tb;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [3:0] cnd = 4'h0;
  logic ser = 1'b0;
  logic lrx = 1'b0;
  logic [1:0] coax;
  logic [1:0] opt;
  logic loopd;
  logic irq;
  liuts_pkg::liuts_ctrl_s ctrl;
  logic [7:0] v;
  int failures = 0;
  int checks_done = 0;

  always #25 sys_clk_in = ~sys_clk_in;

  liuts_regs liuts_regs_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .rx_los_in(cnd[3]), .rx_lol_in(cnd[2]),
    .tx_lol_in(cnd[1]), .fifo_err_in(cnd[0]), .ctrl_out(ctrl),
    .coax_tx_out(coax), .optical_tx_out(opt), .serial_tx_data_in(ser),
    .line_rx_in(lrx), .loop_data_out(loopd), .irq_out(irq));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic pulse(input int i);
    @(posedge sys_clk_in);
    cnd[i] <= 1'b1;
    @(posedge sys_clk_in);
    cnd[i] <= 1'b0;
  endtask

  task automatic t_reset_vals();
    rreg(4'h2, v); chk(v, 8'h00);
    rreg(4'h3, v); chk(v, 8'hA8);
    rreg(4'h4, v); chk(v, 8'h80);
    chk(ctrl.coax_mode, 1'b1);
    chk(ctrl.optical_mode, 1'b0);
    rreg(4'hF, v); chk(v, 8'h00);
  endtask

  task automatic t_ctrl_bits();
    wreg(4'h2, 8'h01); settle(2);
    chk(ctrl.equalizer_en, 1'b1);
    wreg(4'h2, 8'h00); settle(2);
    chk(ctrl.equalizer_en, 1'b0);
    wreg(4'h3, 8'h02); settle(2); chk(ctrl.boost_level, 2'h1);
    wreg(4'h3, 8'h06); settle(2); chk(ctrl.boost_level, 2'h3);
    wreg(4'h3, 8'h04); settle(2); chk(ctrl.boost_level, 2'h3);
    wreg(4'h3, 8'h00); settle(2); chk(ctrl.boost_level, 2'h0);
  endtask

  task automatic t_loopback();
    wreg(4'h3, 8'h01); settle(2);
    chk(ctrl.loopback_en, 1'b1);
    @(posedge sys_clk_in);
    lrx <= 1'b1; settle(2); chk(loopd, 1'b1);
    @(posedge sys_clk_in);
    lrx <= 1'b0; settle(2); chk(loopd, 1'b0);
    wreg(4'h3, 8'h00); settle(2);
    @(posedge sys_clk_in);
    lrx <= 1'b1; settle(2); chk(loopd, 1'b0);
  endtask

  task automatic t_line_mode();
    @(posedge sys_clk_in);
    ser <= 1'b1;
    wreg(4'h4, 8'h00); settle(2);
    chk(ctrl.optical_mode, 1'b1);
    chk(ctrl.coax_mode, 1'b0);
    chk(opt, 2'h2);
    chk(coax, 2'h0);
    wreg(4'h4, 8'h80); settle(2);
    chk(coax, 2'h2);
    chk(opt, 2'h0);
    @(posedge sys_clk_in);
    ser <= 1'b0; settle(2); chk(coax, 2'h1);
  endtask

  task automatic t_status();
    logic [7:0] pos [4] = '{8'h01, 8'h02, 8'h08, 8'h10};
    for (int i = 0; i < 4; i++)
    begin
      pulse(i);
      rreg(4'h5, v); chk(v, pos[i]);
      rreg(4'h5, v); chk(v, 8'h00);
    end
    @(posedge sys_clk_in);
    cnd[3] <= 1'b1;
    rreg(4'h5, v); chk(v, 8'h10);
    rreg(4'h5, v); chk(v, 8'h10);
    @(posedge sys_clk_in);
    cnd[3] <= 1'b0;
    rreg(4'h5, v); chk(v, 8'h10);
    rreg(4'h5, v); chk(v, 8'h00);
  endtask

  task automatic t_fifo_reset();
    pulse(0);
    wreg(4'h8, 8'h01); settle(2);
    chk(ctrl.fifo_ptr_reset, 1'b1);
    rreg(4'h5, v); chk(v, 8'h00);
    pulse(0);
    rreg(4'h5, v); chk(v, 8'h00);
    wreg(4'h8, 8'h00); settle(2);
    chk(ctrl.fifo_ptr_reset, 1'b0);
  endtask

  task automatic t_irq();
    wreg(4'h9, 8'h01);
    pulse(0); settle(1); chk(irq, 1'b1);
    rreg(4'h5, v); chk(v, 8'h01);
    settle(1); chk(irq, 1'b0);
    wreg(4'h9, 8'h10);
    pulse(0); settle(2); chk(irq, 1'b0);
    rreg(4'h5, v); chk(v, 8'h01);
  endtask

  task automatic t_reserved();
    wreg(4'h6, 8'hFF);
    wreg(4'h7, 8'hFF);
    wreg(4'h5, 8'hFF);
    rreg(4'h6, v); chk(v, 8'h00);
    rreg(4'h7, v); chk(v, 8'h00);
    rreg(4'h5, v); chk(v, 8'h00);
  endtask

  initial
  begin
    #2000000;
    failures++;
    print_verdict();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    chk(ctrl.coax_mode, 1'b1);
    chk(ctrl.optical_mode, 1'b0);
    rst_in <= 1'b0;
    t_reset_vals();
    t_ctrl_bits();
    t_loopback();
    t_line_mode();
    t_status();
    t_fifo_reset();
    t_irq();
    t_reserved();
    print_verdict();
  end
endmodule
